// file: common/asc_pkg.sv
package asc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FILL_COUNT  = 8'h01;
    localparam logic [7:0] OFS_SCAN_STATE  = 8'h04;
    localparam logic [7:0] OFS_OSC_SELECT  = 8'h18;
    localparam logic [7:0] OFS_CYCLE_COUNT = 8'h19;
    localparam logic [7:0] OFS_SCAN_LAUNCH = 8'h1E;
    localparam logic [7:0] OFS_SCAN_CANCEL = 8'h1F;
    localparam logic [7:0] OFS_CHAN_SELECT = 8'h20;
    localparam logic [7:0] OFS_PIN_ARRANGE = 8'h24;

    // ------------------------------------------------------------
    // Reset values, field positions, figures
    // ------------------------------------------------------------
    localparam logic [1:0] RST_PIN_ARRANGE = 2'h0;
    localparam logic [1:0] RST_CHAN_SELECT = 2'h3;
    localparam logic       RST_OSC_SELECT  = 1'h0;
    localparam logic [7:0] RST_CYCLE_COUNT = 8'h00;
    localparam logic [1:0] RST_STATE_CODE  = 2'h0;
    localparam logic [4:0] RST_FILL_COUNT  = 5'h00;
    localparam int         STATE_CODE_LSB  = 1;
    localparam logic [7:0] MIN_FAST_CYCLE  = 8'h15;
    localparam logic [7:0] MIN_LP_CYCLE    = 8'h12;
    localparam logic [4:0] MAX_FILL_COUNT  = 5'h10;
    localparam logic [7:0] GCALL_RESET     = 8'h06;
    localparam logic [6:0] GCALL_ADDR      = 7'h00;

    // Scan state codes
    localparam logic [1:0] CODE_OFF        = 2'h0;
    localparam logic [1:0] CODE_ON         = 2'h1;
    localparam logic [1:0] CODE_ON_ERR     = 2'h3;

    typedef enum logic [1:0] {
        ASC_TWO_SE      = 2'h0,
        ASC_ONE_SE_RGS  = 2'h1,
        ASC_PSEUDO_DIFF = 2'h2
    } asc_arr_t;

    typedef struct packed {
        asc_arr_t   arrangement;
        logic       scan_include_second;
        logic       scan_include_first;
        logic       oscillator_choice;
        logic [7:0] cycle_clock_total;
    } asc_cfg_t;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ADDR  = 6'h02,
        ST_REG   = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_GCALL = 6'h20
    } asc_state_t;

endpackage

// file: dv/asc_host.sv
`timescale 1ns/1ps
module asc_host (
    // Clock
    input  wire logic clk_sys,
    // Resolved data line
    input  wire logic sda,
    // Host drive
    output logic      scl,
    output logic      sda_low,
    // Frame results
    output logic [7:0] rd_byte,
    output logic      rd_stb,
    output logic      ack_seen
);
    // --------------------------------
    // Bus steps, 20 ns each, 80 ns per bit
    // --------------------------------
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_stb = 1'b0;
        rd_byte = 8'h00;
        ack_seen = 1'b0;
    end
    task automatic step(input logic c, input logic d);
        scl <= c;
        sda_low <= d;
        repeat (2) @(posedge clk_sys);
    endtask
    // Data moves only while SCL is low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        step(1'b0, ~b);
        step(1'b1, ~b);
        s = sda;
        step(1'b1, ~b);
        step(1'b0, ~b);
    endtask
    // Serves as repeated start too: SCL is driven low in the same step that SDA is freed
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic send(input logic [7:0] b, output logic k);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        k = ~s;
    endtask
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1,
                         input logic [7:0] b2, input int n);
        logic k0, k1, k2;
        k2 = 1'b1;
        start();
        send(b0, k0);
        send(b1, k1);
        if (n > 2)
            send(b2, k2);
        stop();
        ack_seen = k0 & k1 & k2;
    endtask
    // One byte per read, ended by NACK
    task automatic rd(input logic [6:0] a, input logic [7:0] ofs);
        logic       k;
        logic [7:0] b;
        start();
        send({a, 1'b0}, k);
        send(ofs, k);
        start();
        send({a, 1'b1}, k);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(1'b1, k);
        stop();
        rd_byte <= b;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
    endtask
endmodule

// file: dv/tb_asc_control.sv
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module tb_asc_control;
    localparam logic [6:0] ADDR = 7'h18;
    localparam logic [7:0] OFS [9] = '{8'h01, 8'h04, 8'h18, 8'h19, 8'h1E,
                                      8'h1F, 8'h20, 8'h24, 8'h30};
    localparam logic [7:0] CNT [6] = '{8'h00, 8'h12, 8'h13, 8'h15, 8'h16,
                                      8'hFF};
    logic              clk_sys, srst, scl, sda_low, sda_o, sda_oe, sda_w;
    logic [2:0]        mode;
    logic              scan_done, scan_error, entry_stored;
    logic              conv_busy, conv_start, rd_stb, ack_seen;
    asc_pkg::asc_cfg_t cfg;
    logic [7:0]        exp_q [$];
    logic [7:0]        rd_byte, mon_e, v, lim;
    int                n_mismatch, n_tests, n_start, k;
    // Open drain wire with pull-up
    assign sda_w = ~((sda_oe & ~sda_o) | sda_low);
    asc_control #(.DEV_ADDR(ADDR)) i_asc_control (
        .clk_sys(clk_sys), .srst(srst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .operating_mode_select(mode),
        .scan_done(scan_done), .scan_error(scan_error),
        .entry_stored(entry_stored), .conv_busy(conv_busy),
        .conv_start(conv_start), .cfg(cfg));
    asc_host i_asc_host (
        .clk_sys(clk_sys), .sda(sda_w), .scl(scl), .sda_low(sda_low),
        .rd_byte(rd_byte), .rd_stb(rd_stb), .ack_seen(ack_seen));
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        i_asc_host.frame({ADDR, 1'b0}, ofs, d, 3);
        `CHK(ack_seen, 1'b1)
    endtask
    task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
        exp_q.push_back(e);
        i_asc_host.rd(ADDR, ofs);
    endtask
    task automatic wrap_up();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // --------------------------------
    // Result watcher
    // --------------------------------
    always @(posedge clk_sys)
        if (rd_stb === 1'b1)
        begin
            mon_e = exp_q.pop_front();
            `CHK(rd_byte, mon_e)
        end
    always @(posedge clk_sys)
        if (conv_start === 1'b1)
            n_start++;
    // A full run needs about 28k cycles; nearly three times that means a hang
    initial
    begin
        #800000;
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        {srst, mode, scan_done, scan_error, entry_stored} <= 7'h40;
        {n_mismatch, n_tests, n_start} = '0;
        void'($urandom(32'h1181));
        tick(5);
        srst <= 1'b0;
        tick(4);
        `CHK(cfg.cycle_clock_total, 8'h15)
        foreach (OFS[i])
        begin
            v = (OFS[i] == 8'h20) ? 8'h03 : 8'h00;
            rd(OFS[i], v);
        end
        for (int i = 0; i < 4; i++)
        begin
            v = {6'($urandom()), 2'(i)};
            wr(8'h24, v);
            rd(8'h24, {6'h00, v[1:0]});
            `CHK(cfg.arrangement, (v[1:0] == 2'h3) ? 2'h0 : v[1:0])
        end
        for (int i = 0; i < 8; i++)
        begin
            tick(1);
            mode <= (i < 4) ? 3'h1 : 3'(4 + $urandom_range(3, 0));
            v = {6'($urandom()), 2'(i)};
            wr(8'h20, v);
            rd(8'h20, {6'h00, v[1:0]});
            `CHK(cfg.scan_include_second, v[1] & mode[2])
            `CHK(cfg.scan_include_first, v[0] | ~mode[2])
        end
        for (int i = 0; i < 12; i++)
        begin
            v = CNT[i % 6];
            if (i == 11)
                v = 8'($urandom());
            lim = (i < 6) ? 8'h15 : 8'h12;
            wr(8'h18, {7'($urandom()), 1'(i / 6)});
            wr(8'h19, v);
            rd(8'h19, v);
            rd(8'h18, {7'h00, 1'(i / 6)});
            `CHK(cfg.oscillator_choice, 1'(i / 6))
            `CHK(cfg.cycle_clock_total, (v > lim) ? v : lim)
        end
        tick(1);
        mode <= 3'h4;
        k = n_start;
        wr(8'h1E, 8'h01);
        `CHK(n_start, k + 1)
        `CHK(conv_busy, 1'b1)
        repeat (3)
        begin
            tick(1);
            entry_stored <= 1'b1;
            tick(1);
            entry_stored <= 1'b0;
        end
        rd(8'h04, 8'h02);
        scan_error <= 1'b1;
        rd(8'h04, 8'h06);
        scan_error <= 1'b0;
        wr(8'h1F, 8'h01);
        `CHK(conv_busy, 1'b0)
        rd(8'h04, 8'h00);
        rd(8'h01, 8'h03);
        wr(8'h1E, 8'h01);
        rd(8'h01, 8'h00);
        mode <= 3'h1;
        rd(8'h04, 8'h00);
        mode <= 3'h6;
        `CHK(conv_busy, 1'b1)
        scan_done <= 1'b1;
        tick(1);
        scan_done <= 1'b0;
        tick(2);
        `CHK(conv_busy, 1'b0)
        wr(8'h20, 8'h00);
        wr(8'h19, 8'h40);
        wr(8'h1E, 8'h01);
        rd(8'h04, 8'h02);
        i_asc_host.frame(8'h00, 8'h06, 8'h00, 2);
        `CHK(ack_seen, 1'b1)
        `CHK(conv_busy, 1'b0)
        rd(8'h04, 8'h00);
        rd(8'h20, 8'h03);
        rd(8'h19, 8'h00);
        i_asc_host.frame({7'h19, 1'b0}, 8'h20, 8'h00, 3);
        `CHK(ack_seen, 1'b0)
        rd(8'h20, 8'h03);
        tick(4);
        `CHK(exp_q.size(), 0)
        wrap_up();
    end
endmodule

// file: hdl/asc_control.sv
`timescale 1ns/1ps
// Functional notes
// R01: Arrangement 00/11 two SE, 01 RGS, 10 pseudo-diff
// R02: Arrangement bits 7:2 read zero, reset zero
// R03: Channel select resets with both bits set
// R04: Bit1 includes second, bit0 first input
// R05: Launch write raises busy, starts first conversion
// R06: Cancel write stops conversion, busy low
// R07: Host reads fill status after cancelling
// R08: Scan state cleared on resets and launch
// R09: State code 00 off, 01 on, 11 error
// R10: Scan state bit0 and bits 7:3 zero
// R11: Oscillator bit 0 fast, 1 low-power
// R12: Cycle count register sets oscillator clocks
// R13: Fast oscillator minimum cycle is 21 clocks
// R14: Low-power oscillator minimum cycle is 18 clocks
// R15: Scanning only with mode select 100b-111b
// R16: Fill count cleared on resets and launch
// R17: Launch, cancel pulses; cancel wins ties
// R18: Busy holds until scan done or cancel
module asc_control #(
    parameter logic [6:0] DEV_ADDR = 7'h18
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // Serial control bus
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe,
    // Converter side
    input  wire logic [2:0]       operating_mode_select,
    input  wire logic             scan_done,
    input  wire logic             scan_error,
    input  wire logic             entry_stored,
    output logic                  conv_busy,
    output logic                  conv_start,
    output asc_pkg::asc_cfg_t     cfg
);

    // ------------------------------------------------------------
    // Bus sampling
    // ------------------------------------------------------------
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic       scl_p_q;
    logic       sda_p_q;

    always_ff @(posedge clk_sys)
    begin
        scl_s_q <= {scl_s_q[0], scl_i};
        sda_s_q <= {sda_s_q[0], sda_i};
        scl_p_q <= scl_s_q[1];
        sda_p_q <= sda_s_q[1];
    end

    wire scl_rise = scl_s_q[1] & ~scl_p_q;
    wire scl_fall = ~scl_s_q[1] & scl_p_q;
    wire bus_start = scl_s_q[1] & scl_p_q & ~sda_s_q[1] & sda_p_q;
    wire bus_stop  = scl_s_q[1] & scl_p_q & sda_s_q[1] & ~sda_p_q;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    asc_pkg::asc_state_t st_q;
    asc_pkg::asc_state_t st_d;
    logic [3:0] bitn_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic       ack_q;
    logic       gc_q;
    logic [7:0] rdata;

    // Byte done: falling edge after the eighth data bit
    wire byte_done = scl_fall & (bitn_q == 4'h8);
    wire addr_hit  = sh_q[7:1] == DEV_ADDR;
    wire gcall_hit = (sh_q[7:1] == asc_pkg::GCALL_ADDR) & ~sh_q[0];
    wire wr_pulse  = byte_done & (st_q == asc_pkg::ST_WDATA);
    wire rst_all   = srst | gc_q;

    always_comb
    begin
        st_d = st_q;
        if (byte_done)
        begin
            case (st_q)
                asc_pkg::ST_ADDR:
                    if (addr_hit)
                        st_d = sh_q[0] ? asc_pkg::ST_RDATA
                                       : asc_pkg::ST_REG;
                    else if (gcall_hit)
                        st_d = asc_pkg::ST_GCALL;
                    else
                        st_d = asc_pkg::ST_IDLE;
                asc_pkg::ST_REG:   st_d = asc_pkg::ST_WDATA;
                asc_pkg::ST_GCALL: st_d = asc_pkg::ST_IDLE;
                default:           st_d = st_q;
            endcase
        end
        // Master not acknowledging ends a read
        if (scl_rise & (bitn_q == 4'h9) & (st_q == asc_pkg::ST_RDATA)
            & sda_s_q[1])
            st_d = asc_pkg::ST_IDLE;
        if (bus_start)
            st_d = asc_pkg::ST_ADDR;
        if (bus_stop)
            st_d = asc_pkg::ST_IDLE;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_q   <= asc_pkg::ST_IDLE;
            bitn_q <= 4'h0;
            sh_q   <= 8'h00;
            tx_q   <= 8'h00;
            ptr_q  <= 8'h00;
            ack_q  <= 1'b0;
            gc_q   <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            gc_q <= byte_done & (st_q == asc_pkg::ST_GCALL)
                    & (sh_q == asc_pkg::GCALL_RESET);
            if (bus_start | bus_stop)
            begin
                bitn_q <= 4'h0;
                ack_q  <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (bitn_q < 4'h8)
                begin
                    sh_q   <= {sh_q[6:0], sda_s_q[1]};
                    bitn_q <= bitn_q + 4'h1;
                end
                else if (bitn_q == 4'h9)
                    bitn_q <= 4'hA;
            end
            else if (scl_fall)
            begin
                if (byte_done)
                begin
                    bitn_q <= 4'h9;
                    // General call reset byte is acknowledged as well
                    ack_q  <= ((st_q != asc_pkg::ST_RDATA)
                              & (st_d != asc_pkg::ST_IDLE))
                              | ((st_q == asc_pkg::ST_GCALL)
                              & (sh_q == asc_pkg::GCALL_RESET));
                    if (st_q == asc_pkg::ST_REG)
                        ptr_q <= sh_q;
                    if (wr_pulse)
                        ptr_q <= ptr_q + 8'h01;
                end
                else if (bitn_q == 4'hA)
                begin
                    bitn_q <= 4'h0;
                    ack_q  <= 1'b0;
                    if (st_q == asc_pkg::ST_RDATA)
                    begin
                        tx_q  <= rdata;
                        ptr_q <= ptr_q + 8'h01;
                    end
                end
                else if (bitn_q != 4'h0)
                    tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // Open drain: only ever pull low
    assign sda_o  = 1'b0;
    assign sda_oe = ack_q | ((st_q == asc_pkg::ST_RDATA)
                    & (bitn_q <= 4'h8) & ~tx_q[7]);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [1:0] arr_q;
    logic [1:0] chsel_q;
    logic       osc_q;
    logic [7:0] ncnt_q;
    logic [1:0] code_q;
    logic [4:0] fill_q;
    logic       busy_q;

    wire [7:0] wdata = sh_q;
    wire wr_arr    = wr_pulse & (ptr_q == asc_pkg::OFS_PIN_ARRANGE);
    wire wr_chsel  = wr_pulse & (ptr_q == asc_pkg::OFS_CHAN_SELECT);
    wire wr_osc    = wr_pulse & (ptr_q == asc_pkg::OFS_OSC_SELECT);
    wire wr_ncnt   = wr_pulse & (ptr_q == asc_pkg::OFS_CYCLE_COUNT);
    wire launch    = wr_pulse & (ptr_q == asc_pkg::OFS_SCAN_LAUNCH)
                     & wdata[0]; // R05 R17
    wire cancel    = wr_pulse & (ptr_q == asc_pkg::OFS_SCAN_CANCEL)
                     & wdata[0]; // R06 R17
    wire auto_mode = operating_mode_select[2]; // R15
    wire [1:0] code_d = ~(busy_q & auto_mode) ? asc_pkg::CODE_OFF
                      : scan_error ? asc_pkg::CODE_ON_ERR
                      : asc_pkg::CODE_ON; // R09

    always_ff @(posedge clk_sys)
    begin
        if (rst_all)
        begin
            arr_q   <= asc_pkg::RST_PIN_ARRANGE; // R02
            chsel_q <= asc_pkg::RST_CHAN_SELECT; // R03
            osc_q   <= asc_pkg::RST_OSC_SELECT;  // R11
            ncnt_q  <= asc_pkg::RST_CYCLE_COUNT; // R12
            code_q  <= asc_pkg::RST_STATE_CODE;  // R08
            fill_q  <= asc_pkg::RST_FILL_COUNT;  // R16
            busy_q  <= 1'b0;
        end
        else
        begin
            if (wr_arr)
                arr_q <= wdata[1:0];
            if (wr_chsel)
                chsel_q <= wdata[1:0]; // R04
            if (wr_osc)
                osc_q <= wdata[0];
            if (wr_ncnt)
                ncnt_q <= wdata;
            code_q <= launch ? asc_pkg::RST_STATE_CODE : code_d; // R08
            if (launch)
                fill_q <= asc_pkg::RST_FILL_COUNT; // R16
            else if (entry_stored & (fill_q < asc_pkg::MAX_FILL_COUNT))
                fill_q <= fill_q + 5'h01;
            // Cancel is checked first so a tie leaves the scan idle
            // A fresh launch outranks the end of the previous scan
            if (cancel)
                busy_q <= 1'b0; // R06 R17
            else if (launch)
                busy_q <= 1'b1; // R05 R18
            else if (scan_done)
                busy_q <= 1'b0; // R18
        end
    end

    // Launch and cancel bits are write-only and read as zero
    always_comb
    begin
        case (ptr_q)
            asc_pkg::OFS_FILL_COUNT:  rdata = {3'h0, fill_q};
            asc_pkg::OFS_SCAN_STATE:  rdata = {5'h00, code_q, 1'b0}; // R10
            asc_pkg::OFS_OSC_SELECT:  rdata = {7'h00, osc_q};
            asc_pkg::OFS_CYCLE_COUNT: rdata = ncnt_q;
            asc_pkg::OFS_CHAN_SELECT: rdata = {6'h00, chsel_q};
            asc_pkg::OFS_PIN_ARRANGE: rdata = {6'h00, arr_q}; // R02
            default:                  rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    wire [7:0] cyc_min = osc_q ? asc_pkg::MIN_LP_CYCLE
                               : asc_pkg::MIN_FAST_CYCLE;

    assign cfg.arrangement = (arr_q == 2'h3) ? asc_pkg::ASC_TWO_SE
                           : asc_pkg::asc_arr_t'(arr_q); // R01
    assign cfg.scan_include_second = chsel_q[1] & auto_mode; // R04 R15
    assign cfg.scan_include_first  = chsel_q[0] | ~auto_mode; // R15
    assign cfg.oscillator_choice   = osc_q; // R11
    assign cfg.cycle_clock_total   = (ncnt_q <= cyc_min) ? cyc_min
                                   : ncnt_q; // R13 R14
    assign conv_busy  = busy_q;
    assign conv_start = launch & ~cancel; // R05 R17

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    launch_busy_a: assert property ( // R05
        @(posedge clk_sys) disable iff (rst_all)
        launch & ~cancel |=> conv_busy)
        else $error("busy did not rise after launch");
    cancel_wins_a: assert property ( // R06
        @(posedge clk_sys) disable iff (rst_all)
        cancel |=> ~conv_busy)
        else $error("busy high after cancel");
    tie_start_a: assert property ( // R17
        @(posedge clk_sys) disable iff (rst_all)
        cancel |-> ~conv_start)
        else $error("start issued with cancel");
    busy_hold_a: assert property ( // R18
        @(posedge clk_sys) disable iff (rst_all)
        conv_busy & ~cancel & ~scan_done |=> conv_busy)
        else $error("busy fell without cause");
    state_clear_a: assert property ( // R08
        @(posedge clk_sys) disable iff (srst)
        launch | gc_q |=> code_q == asc_pkg::RST_STATE_CODE)
        else $error("scan state not cleared");
    state_code_a: assert property ( // R09 R10
        @(posedge clk_sys) disable iff (rst_all)
        ##1 code_q != 2'h2 && (ptr_q != asc_pkg::OFS_SCAN_STATE
        || (rdata[0] == 1'b0 && rdata[7:3] == 5'h00)))
        else $error("bad scan state value");
    fast_cycle_a: assert property ( // R13
        @(posedge clk_sys) disable iff (srst)
        ~osc_q |-> cfg.cycle_clock_total ==
        ((ncnt_q > asc_pkg::MIN_FAST_CYCLE) ? ncnt_q
        : asc_pkg::MIN_FAST_CYCLE))
        else $error("fast cycle length wrong");
    lp_cycle_a: assert property ( // R14
        @(posedge clk_sys) disable iff (srst)
        osc_q |-> cfg.cycle_clock_total ==
        ((ncnt_q > asc_pkg::MIN_LP_CYCLE) ? ncnt_q
        : asc_pkg::MIN_LP_CYCLE))
        else $error("low-power cycle length wrong");
    chan_reset_a: assert property ( // R03
        @(posedge clk_sys)
        srst |=> chsel_q == asc_pkg::RST_CHAN_SELECT
        && arr_q == asc_pkg::RST_PIN_ARRANGE)
        else $error("select reset wrong");
    fill_clear_a: assert property ( // R16
        @(posedge clk_sys) disable iff (srst)
        launch |=> fill_q == asc_pkg::RST_FILL_COUNT)
        else $error("fill count not cleared");
    arr_decode_a: assert property ( // R01
        @(posedge clk_sys)
        arr_q == 2'h3 |-> cfg.arrangement == asc_pkg::ASC_TWO_SE)
        else $error("arrangement 11 decode wrong");

    launch_c: cover property (@(posedge clk_sys) launch ##[1:1000] scan_done);
    cancel_c: cover property (@(posedge clk_sys) conv_busy ##1 cancel);
    error_c:  cover property (@(posedge clk_sys)
        code_q == asc_pkg::CODE_ON_ERR);
    gcall_c:  cover property (@(posedge clk_sys) gc_q);

endmodule
